// file: fspo_pkg.sv
// Constants shared by the flash security and protection option block.
// Assumes a 16-bit flash address space and 8-bit option bytes.
package fspo_pkg;

    // ==========================================================
    // Register offsets (byte addresses on the APB)
    localparam logic [7:0] FSPO_OFF_OPTION = 8'h00;
    localparam logic [7:0] FSPO_OFF_CONFIG = 8'h04;
    localparam logic [7:0] FSPO_OFF_PROTECT = 8'h08;
    localparam logic [7:0] FSPO_OFF_STATUS = 8'h0C;
    localparam logic [7:0] FSPO_OFF_ADDR = 8'h10;
    localparam logic [7:0] FSPO_OFF_DATA = 8'h14;
    localparam logic [7:0] FSPO_OFF_CMD = 8'h18;

    // ==========================================================
    // Field positions and masks
    localparam int FSPO_OPT_KEY_ENABLE_BIT = 7;
    localparam int FSPO_OPT_NORED_BIT = 6;
    localparam logic [7:0] FSPO_OPT_IMPL_MASK = 8'hC3;
    localparam int FSPO_CFG_KEY_ACCESS_BIT = 5;
    localparam int FSPO_PROT_DIS_BIT = 0;
    localparam int FSPO_STAT_VIOL_BIT = 5;
    localparam int FSPO_STAT_BUSY_BIT = 1;
    localparam int FSPO_STAT_SECURE_BIT = 0;
    localparam logic [1:0] FSPO_SEC_UNSECURED = 2'b10;

    // ==========================================================
    // Values after reset (before the nonvolatile reload)
    localparam logic [7:0] FSPO_RST_OPTION = 8'h00;
    localparam logic [7:0] FSPO_RST_CONFIG = 8'h00;
    localparam logic [7:0] FSPO_RST_PROTECT = 8'hFF;
    localparam logic [15:0] FSPO_RST_ADDR = 16'h0000;

    // ==========================================================
    // Backdoor key window and counts
    localparam logic [15:0] FSPO_KEY_BASE = 16'hFFB0;
    localparam logic [3:0] FSPO_KEY_LEN = 4'h8;
    localparam int FSPO_BLOCK_SHIFT = 9;

    // ==========================================================
    // Flash command codes
    localparam logic [7:0] FSPO_CMD_BLANK = 8'h05;
    localparam logic [7:0] FSPO_CMD_PROG = 8'h20;
    localparam logic [7:0] FSPO_CMD_BURST = 8'h25;
    localparam logic [7:0] FSPO_CMD_PAGE_ERASE = 8'h40;
    localparam logic [7:0] FSPO_CMD_MASS_ERASE = 8'h41;

    typedef enum logic [1:0] {FSPO_ST_LOAD, FSPO_ST_IDLE, FSPO_ST_CMP} fspo_state_t;

endpackage : fspo_pkg

// file: fspo_key_if.sv
// Link between the controller and the captured key store.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
interface fspo_key_if;
    logic wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [2:0] rd_idx;
    logic [7:0] rd_data;
    modport ctl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : fspo_key_if

// file: fspo_key_mem.sv
// Eight-byte store for the comparison key entered by firmware.
// Assumes one write or one read per cycle; read data lags by one edge.
`timescale 1ns/1ps
module fspo_key_mem (
    input wire logic pclk,
    input wire logic presetn,
    fspo_key_if.mem kif
);
    // ==========================================================
    // Storage
    logic [7:0] key_mem_ff [8];
    logic [7:0] rd_data_ff;

    // Byte write, cleared at reset so no stale key survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                key_mem_ff[i] <= 8'h00;
            end
        end else if (kif.wr_en) begin
            key_mem_ff[kif.wr_idx] <= kif.wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= key_mem_ff[kif.rd_idx];
        end
    end

    assign kif.rd_data = rd_data_ff;

endmodule : fspo_key_mem

// file: fspo_ctrl.sv
// Flash option, security and block protection control behind an APB slave.
// Assumes nonvolatile bytes and the stored key are stable, same-clock inputs.
//
// How it works
// - Option register reloads from the nonvolatile option byte after every reset.
// - Key comparison never unlocks while the key enable bit is clear.
// - Eight ordered matching key bytes drop security until next reset.
// - Key bytes count only from secure firmware; debug writes are ignored.
// - Option bit 6 set disables vector redirection.
// - Security code 2'b10 alone means unsecured; all others mean secure.
// - While secure, memory access from unsecured sources is blocked.
// - Key match or blank check forces the security code to 2'b10.
// - Key window writes go to key capture or to flash by key access bit.
// - Clearing key access after eight bytes compares and unlocks on match.
// - Protection register reloads from the nonvolatile protect byte at reset.
// - Protection readable; user writes only shrink the boundary select value.
// - With protection disabled, user writes leave protection unchanged.
// - Debug writes change protection freely.
// - Boundary select bits 7:1 end the unprotected region; top block protected.
// - Program or erase inside the protected block is refused.
// - Protect disable 0 enables block protection; 1 protects nothing.
// - A refused command is dropped and sets the violation status flag.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module fspo_ctrl
    import fspo_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] nv_option_byte,
    input wire logic [7:0] nv_protect_byte,
    input wire logic [63:0] backdoor_compare_key,
    input wire logic blank_check_ok,
    output logic mem_lock,
    output logic vector_redirect_en,
    output logic flash_wr,
    output logic flash_cmd_go,
    output logic [7:0] flash_cmd,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_data
);

    // ==========================================================
    // Helper functions
    function automatic logic sec_is_secure(input logic [1:0] code);
        sec_is_secure = (code != FSPO_SEC_UNSECURED);
    endfunction : sec_is_secure

    function automatic logic addr_protected(input logic [15:0] addr, input logic [7:0] prot);
        // Protected block spans from just above the boundary to the top of flash
        addr_protected = !prot[FSPO_PROT_DIS_BIT] && (addr[15:FSPO_BLOCK_SHIFT] > prot[7:1]);
    endfunction : addr_protected

    // ==========================================================
    // State
    fspo_state_t state_ff, nxt_state;
    logic [7:0] option_ff, config_ff, protect_ff, flash_cmd_ff, flash_data_ff;
    logic [15:0] addr_ff;
    logic viol_ff, pready_ff, pslverr_ff, mem_lock_ff, redirect_ff;
    logic flash_wr_ff, flash_go_ff, key_bad_ff, match_ff;
    logic [31:0] prdata_ff;
    logic [3:0] key_idx_ff, cmp_cnt_ff;

    fspo_key_if kif ();
    fspo_key_mem u_key_mem (.pclk(pclk), .presetn(presetn), .kif(kif));

    // ==========================================================
    // APB decode
    wire setup = psel && !penable;
    wire wr_acc = psel && penable && pready_ff && pwrite;
    wire from_debug = pprot[1]; // Non-secure master is the debug path
    wire hit_opt = (paddr == FSPO_OFF_OPTION);
    wire hit_cfg = (paddr == FSPO_OFF_CONFIG);
    wire hit_prot = (paddr == FSPO_OFF_PROTECT);
    wire hit_stat = (paddr == FSPO_OFF_STATUS);
    wire hit_addr = (paddr == FSPO_OFF_ADDR);
    wire hit_data = (paddr == FSPO_OFF_DATA);
    wire hit_cmd = (paddr == FSPO_OFF_CMD);
    wire mapped = hit_opt | hit_cfg | hit_prot | hit_stat | hit_addr | hit_data | hit_cmd;
    wire key_access = config_ff[FSPO_CFG_KEY_ACCESS_BIT];
    wire key_enable = option_ff[FSPO_OPT_KEY_ENABLE_BIT];
    wire in_key_win = (addr_ff[15:3] == FSPO_KEY_BASE[15:3]);

    // Key window steering
    wire key_wr = wr_acc && hit_data && in_key_win && key_access;
    wire key_take = key_wr && !from_debug;
    wire key_in_order = (key_idx_ff == {1'b0, addr_ff[2:0]});
    wire data_to_flash = wr_acc && hit_data && !(in_key_win && key_access);
    wire key_access_fall = wr_acc && hit_cfg && key_access && !pwdata[FSPO_CFG_KEY_ACCESS_BIT];
    wire cmp_start = key_access_fall && (key_idx_ff == FSPO_KEY_LEN) && !key_bad_ff;

    // Compare walk: count k reads byte k and checks byte k-1
    wire cmp_done = (state_ff == FSPO_ST_CMP) && (cmp_cnt_ff == FSPO_KEY_LEN);
    wire [2:0] cmp_prev = 3'(cmp_cnt_ff - 4'h1);
    wire byte_ok = (kif.rd_data == backdoor_compare_key[cmp_prev*8 +: 8]);
    wire unlock_key = cmp_done && match_ff && byte_ok && key_enable;
    wire unlock = unlock_key || blank_check_ok;

    // Command launch and protection check
    wire cmd_wr = wr_acc && hit_cmd;
    wire [7:0] cmd_code = pwdata[7:0];
    wire cmd_changes = (cmd_code == FSPO_CMD_PROG) || (cmd_code == FSPO_CMD_BURST)
        || (cmd_code == FSPO_CMD_PAGE_ERASE) || (cmd_code == FSPO_CMD_MASS_ERASE);
    wire any_prot = !protect_ff[FSPO_PROT_DIS_BIT];
    wire cmd_hits_prot = (cmd_code == FSPO_CMD_MASS_ERASE) ? any_prot : addr_protected(addr_ff, protect_ff);
    wire cmd_refused = cmd_wr && cmd_changes && cmd_hits_prot;
    wire viol_clr = wr_acc && hit_stat && pwdata[FSPO_STAT_VIOL_BIT];

    // Protection write filter: debug free, user may only tighten
    wire [7:0] prot_wd = pwdata[7:0];
    wire user_tighten = !protect_ff[FSPO_PROT_DIS_BIT] && !prot_wd[FSPO_PROT_DIS_BIT]
        && (prot_wd[7:1] < protect_ff[7:1]);
    wire prot_take = wr_acc && hit_prot && (from_debug || user_tighten);

    // Read mux; reserved bits read zero
    wire [7:0] stat_rd = {2'b00, viol_ff, 3'b000, (state_ff == FSPO_ST_CMP), sec_is_secure(option_ff[1:0])};
    wire [7:0] rd_byte = hit_opt ? (option_ff & FSPO_OPT_IMPL_MASK)
        : hit_cfg ? config_ff
        : hit_prot ? protect_ff
        : hit_stat ? stat_rd
        : hit_cmd ? flash_cmd_ff
        : hit_data ? flash_data_ff : 8'h00;
    wire [31:0] rd_word = hit_addr ? {16'h0000, addr_ff} : {24'h00_0000, rd_byte};

    assign kif.wr_en = key_take && key_in_order;
    assign kif.wr_idx = addr_ff[2:0];
    assign kif.wr_data = pwdata[7:0];
    assign kif.rd_idx = cmp_cnt_ff[2:0];

    // ==========================================================
    // State machine: one load cycle after reset release, then idle
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            FSPO_ST_LOAD: nxt_state = FSPO_ST_IDLE;
            FSPO_ST_IDLE: if (cmp_start) nxt_state = FSPO_ST_CMP;
            FSPO_ST_CMP: if (cmp_done) nxt_state = FSPO_ST_IDLE;
            // The fourth code is unused; fall back to a fresh reload
            default: nxt_state = FSPO_ST_LOAD;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= FSPO_ST_LOAD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Option register: nonvolatile reload, then only unlock can touch it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option_ff <= FSPO_RST_OPTION;
        end else if (state_ff == FSPO_ST_LOAD) begin
            option_ff <= nv_option_byte & FSPO_OPT_IMPL_MASK;
        end else if (unlock) begin
            option_ff[1:0] <= FSPO_SEC_UNSECURED;
        end
    end

    // Protection register: reload, then filtered writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protect_ff <= FSPO_RST_PROTECT;
        end else if (state_ff == FSPO_ST_LOAD) begin
            protect_ff <= nv_protect_byte;
        end else if (prot_take) begin
            protect_ff <= prot_wd;
        end
    end

    // Config, address and violation flag; a new violation beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_ff <= FSPO_RST_CONFIG;
            addr_ff <= FSPO_RST_ADDR;
            viol_ff <= 1'b0;
        end else begin
            if (wr_acc && hit_cfg) config_ff <= pwdata[7:0] & (8'h01 << FSPO_CFG_KEY_ACCESS_BIT);
            if (wr_acc && hit_addr) addr_ff <= pwdata[15:0];
            viol_ff <= cmd_refused || (viol_ff && !viol_clr);
        end
    end

    // Key entry tracking; a skipped or repeated byte spoils the sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_idx_ff <= 4'h0;
            key_bad_ff <= 1'b0;
        end else if (key_access_fall || (wr_acc && hit_cfg && !key_access)) begin
            key_idx_ff <= 4'h0;
            key_bad_ff <= 1'b0;
        end else if (key_take) begin
            key_idx_ff <= key_in_order ? key_idx_ff + 4'h1 : key_idx_ff;
            key_bad_ff <= key_bad_ff || !key_in_order;
        end
    end

    // Compare walk counter and running match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_cnt_ff <= 4'h0;
            match_ff <= 1'b0;
        end else if (cmp_start) begin
            cmp_cnt_ff <= 4'h0;
            match_ff <= 1'b1;
        end else if (state_ff == FSPO_ST_CMP && !cmp_done) begin
            cmp_cnt_ff <= cmp_cnt_ff + 4'h1;
            if (cmp_cnt_ff != 4'h0) match_ff <= match_ff && byte_ok;
        end
    end

    // Flash side strobes; a refused command never reaches the array
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_wr_ff <= 1'b0;
            flash_go_ff <= 1'b0;
            flash_cmd_ff <= 8'h00;
            flash_data_ff <= 8'h00;
        end else begin
            flash_wr_ff <= data_to_flash;
            flash_go_ff <= cmd_wr && !cmd_refused;
            if (cmd_wr) flash_cmd_ff <= cmd_code;
            if (data_to_flash) flash_data_ff <= pwdata[7:0];
        end
    end

    // Security and vector outputs, registered so they are glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_lock_ff <= 1'b1;
            redirect_ff <= 1'b0;
        end else begin
            mem_lock_ff <= sec_is_secure(option_ff[1:0]);
            redirect_ff <= !option_ff[FSPO_OPT_NORED_BIT];
        end
    end

    // APB answer: zero wait states, ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && !mapped;
            prdata_ff <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign mem_lock = mem_lock_ff;
    assign vector_redirect_en = redirect_ff;
    assign flash_wr = flash_wr_ff;
    assign flash_cmd_go = flash_go_ff;
    assign flash_cmd = flash_cmd_ff;
    assign flash_addr = addr_ff;
    assign flash_data = flash_data_ff;

    // ==========================================================
    // Assertions
    sequence s_key_done;
        cmp_done && match_ff && byte_ok;
    endsequence

    a_option_reload: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == FSPO_ST_LOAD |=> option_ff == ($past(nv_option_byte) & FSPO_OPT_IMPL_MASK))
        else $error("option byte not reloaded");
    a_protect_reload: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff == FSPO_ST_LOAD |=> protect_ff == $past(nv_protect_byte))
        else $error("protect byte not reloaded");
    a_key_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        s_key_done and !key_enable and !blank_check_ok |=> $stable(option_ff))
        else $error("key unlocked while disabled");
    a_key_unlock: assert property (@(posedge pclk) disable iff (!presetn)
        s_key_done and key_enable |=> option_ff[1:0] == FSPO_SEC_UNSECURED ##1 !mem_lock)
        else $error("matching key did not unlock");
    a_debug_key_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        key_wr && from_debug |=> $stable(key_idx_ff))
        else $error("debug key byte accepted");
    a_redirect_follows: assert property (@(posedge pclk) disable iff (!presetn)
        state_ff != FSPO_ST_LOAD |-> vector_redirect_en == !$past(option_ff[FSPO_OPT_NORED_BIT]))
        else $error("redirect output wrong");
    a_secure_decode: assert property (@(posedge pclk) disable iff (!presetn)
        mem_lock == ($past(option_ff[1:0]) != 2'b10))
        else $error("security decode wrong");
    a_blank_unlock: assert property (@(posedge pclk) disable iff (!presetn)
        blank_check_ok && state_ff != FSPO_ST_LOAD |=> option_ff[1:0] == FSPO_SEC_UNSECURED)
        else $error("blank check did not unlock");
    a_prot_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && hit_prot && !from_debug && protect_ff[FSPO_PROT_DIS_BIT] |=> $stable(protect_ff))
        else $error("disabled protection changed");
    a_prot_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_wr && cmd_changes && cmd_hits_prot |=> !flash_cmd_go && viol_ff)
        else $error("protected command launched");

endmodule : fspo_ctrl

// file: testbench.sv
// Self-checking bench for the flash option, security and block protection block.
// Assumes fspo_pkg and the design files are compiled first; drives the APB side itself.
`timescale 1ns/1ps
module testbench
    import fspo_pkg::*;
();
    // ==========================================================
    // Signals, model state and counters
    logic pclk, presetn, psel, penable, pwrite, blank_check_ok, pready, pslverr, err;
    logic mem_lock, vector_redirect_en, flash_wr, flash_cmd_go;
    logic [7:0] paddr, nv_option_byte, nv_protect_byte, flash_cmd, flash_data, m_opt, m_prot;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [2:0] pprot;
    logic [63:0] backdoor_compare_key;
    logic [15:0] flash_addr;
    logic [7:0] codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
    int n_fail, check_count, n_wr, n_go, cycles, w0, g0, c;

    fspo_ctrl fspo_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nv_option_byte(nv_option_byte),
        .nv_protect_byte(nv_protect_byte), .backdoor_compare_key(backdoor_compare_key),
        .blank_check_ok(blank_check_ok), .mem_lock(mem_lock), .vector_redirect_en(vector_redirect_en),
        .flash_wr(flash_wr), .flash_cmd_go(flash_cmd_go), .flash_cmd(flash_cmd),
        .flash_addr(flash_addr), .flash_data(flash_data));

    // ==========================================================
    // Clock, pulse counters and hang guard
    initial pclk = 1'b0;
    always #20 pclk = ~pclk;
    // Strobes are counted, not timed, so a one-cycle shift cannot hide a missing pulse
    always @(posedge pclk) begin
        cycles++;
        if (flash_wr === 1'b1) n_wr++;
        if (flash_cmd_go === 1'b1) n_go++;
        if (cycles == 30000) begin
            n_fail++;
            complete_run();
        end
    end

    // ==========================================================
    // Shared tasks
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] p);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pprot <= p;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_reset(input logic [7:0] o, input logic [7:0] p);
        presetn <= 1'b0;
        nv_option_byte <= o;
        nv_protect_byte <= p;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        m_opt = o & 8'hC3;
        m_prot = p;
    endtask : do_reset

    task automatic chk_sec();
        check({31'h0, mem_lock}, {31'h0, m_opt[1:0] != 2'b10}, "lock");
        apb(1'b0, FSPO_OFF_OPTION, 32'h0, 3'b000);
        check(rd, {24'h0, m_opt}, "option");
    endtask : chk_sec

    // Protection write, then read back against the tighten-only model
    task automatic pw(input logic [7:0] d, input logic [2:0] p);
        if (p[1] || (!m_prot[0] && !d[0] && d[7:1] < m_prot[7:1])) m_prot = d;
        apb(1'b1, FSPO_OFF_PROTECT, {24'h0, d}, p);
        apb(1'b0, FSPO_OFF_PROTECT, 32'h0, 3'b000);
        check(rd, {24'h0, m_prot}, "protect");
    endtask : pw

    task automatic cmd(input logic [15:0] a, input logic [7:0] code);
        logic bad;
        bad = !m_prot[0] && (code == FSPO_CMD_MASS_ERASE || (code inside {8'h20, 8'h25, 8'h40}
              && a[15:9] > m_prot[7:1]));
        g0 = n_go;
        apb(1'b1, FSPO_OFF_ADDR, {16'h0, a}, 3'b000);
        apb(1'b1, FSPO_OFF_CMD, {24'h0, code}, 3'b000);
        apb(1'b0, FSPO_OFF_STATUS, 32'h0, 3'b000);
        check({31'h0, rd[5]}, {31'h0, bad}, "violation flag");
        check({31'h0, rd[0]}, {31'h0, m_opt[1:0] != 2'b10}, "status secure");
        check({24'h0, flash_cmd}, {24'h0, code}, "command code");
        check(32'(n_go - g0), {31'h0, !bad}, "command launch");
        if (bad) apb(1'b1, FSPO_OFF_STATUS, 32'h0000_0020, 3'b000);
    endtask : cmd

    // Eight ordered key bytes, then key access cleared to start the compare
    task automatic enter_key(input logic [63:0] k, input logic [2:0] p);
        int i;
        w0 = n_wr;
        apb(1'b1, FSPO_OFF_CONFIG, 32'h0000_0020, 3'b000);
        for (i = 0; i < 8; i++) begin
            apb(1'b1, FSPO_OFF_ADDR, {16'h0, FSPO_KEY_BASE + 16'(i)}, p);
            apb(1'b1, FSPO_OFF_DATA, {24'h0, k[8*i +: 8]}, p);
        end
        apb(1'b1, FSPO_OFF_CONFIG, 32'h0, 3'b000);
        repeat (12) @(posedge pclk);
        if (!p[1]) check(32'(n_wr - w0), 32'h0, "key bytes reached flash");
        if (m_opt[7] && !p[1] && k == backdoor_compare_key) m_opt[1:0] = 2'b10;
        chk_sec();
    endtask : enter_key

    task automatic complete_run();
        $display("Counts: %0d comparisons, %0d mismatches", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run

    // ==========================================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, blank_check_ok, paddr, pwdata, pprot} = '0;
        {n_fail, check_count, n_wr, n_go, cycles} = '0;
        nv_option_byte = 8'h00;
        nv_protect_byte = 8'hFF;
        seed = lfsr(32'hf94d);
        backdoor_compare_key[31:0] = seed;
        seed = lfsr(seed);
        backdoor_compare_key[63:32] = seed;
        // Every security code, with junk in the unimplemented bits
        for (c = 0; c < 4; c++) begin
            do_reset({1'b1, c[0], 4'hA, c[1:0]}, 8'hFF);
            check({31'h0, vector_redirect_en}, {31'h0, !c[0]}, "redirect");
            check({31'h0, mem_lock}, {31'h0, c[1:0] != 2'b10}, "decode");
            apb(1'b0, FSPO_OFF_OPTION, 32'h0, 3'b000);
            check(rd, {24'h0, m_opt}, "option load");
        end
        apb(1'b0, 8'h1C, 32'h0, 3'b000);
        check({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
        apb(1'b1, FSPO_OFF_OPTION, 32'h0000_00FF, 3'b000);
        apb(1'b0, FSPO_OFF_OPTION, 32'h0, 3'b000);
        check(rd, {24'h0, m_opt}, "option write");
        $display("Test option and decode finished");
        // Boundary shrink, growth refused, all codes at the top of flash
        do_reset(8'h81, 8'h80);
        pw(8'h80, 3'b000);
        pw(8'h60, 3'b000);
        pw(8'h70, 3'b000);
        pw(8'h5F, 3'b000);
        foreach (codes[i]) cmd(16'hFFB0, codes[i]);
        cmd(16'h1000, FSPO_CMD_PAGE_ERASE);
        cmd(16'h5FFF, FSPO_CMD_PROG);
        cmd(16'h6000, FSPO_CMD_PROG);
        pw(8'h01, 3'b010);
        pw(8'h00, 3'b000);
        cmd(16'hFFB0, FSPO_CMD_PROG);
        cmd(16'h0000, FSPO_CMD_MASS_ERASE);
        $display("Test protection finished");
        // Key window write with key access clear goes to flash
        seed = lfsr(seed);
        w0 = n_wr;
        apb(1'b1, FSPO_OFF_ADDR, 32'h0000_FFB3, 3'b000);
        apb(1'b1, FSPO_OFF_DATA, {24'h0, seed[7:0]}, 3'b000);
        repeat (2) @(posedge pclk);
        check(32'(n_wr - w0), 32'h1, "flash write pulse");
        check({flash_addr, 8'h0, flash_data}, {16'hFFB3, 8'h0, seed[7:0]}, "flash data");
        $display("Test key window routing finished");
        // Key entry: disabled, from debug, wrong, then correct
        do_reset(8'h01, 8'hFF);
        enter_key(backdoor_compare_key, 3'b000);
        do_reset(8'h81, 8'hFF);
        enter_key(backdoor_compare_key, 3'b010);
        enter_key(backdoor_compare_key ^ 64'h0000_0100_0000_0000, 3'b000);
        enter_key(backdoor_compare_key, 3'b000);
        $display("Test backdoor key finished");
        // Blank check pass unlocks until the next reset
        do_reset(8'h81, 8'hFF);
        blank_check_ok <= 1'b1;
        @(posedge pclk);
        blank_check_ok <= 1'b0;
        repeat (3) @(posedge pclk);
        m_opt[1:0] = 2'b10;
        chk_sec();
        $display("Test blank check finished");
        complete_run();
    end
endmodule : testbench
